// File: design/onac_dev.sv
// device end: sensor ready status, overrides, nv command/status, soft reset, access levels
// assumes the host end on the same clock; read data on the link one cycle after rd
`timescale 1ns/1ns
module onac_dev #(
  parameter int unsigned READY_CYCLES = onac_pkg::READY_CYCLES,
  parameter int unsigned NV_CYCLES = onac_pkg::NV_BUSY_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  onac_link_if.dev link,
  input wire logic i_sensor_valid,
  input wire logic [11:0] i_sensor_temp,
  input wire logic [11:0] i_calc_ch0,
  input wire logic [11:0] i_calc_ch1,
  input wire logic i_nv_single_err,
  input wire logic i_nv_multi_err,
  output logic [11:0] o_lut_index,
  output logic [11:0] o_ch0_data,
  output logic [11:0] o_ch1_data,
  output logic o_nv_commit,
  output logic o_nv_recall,
  output logic o_soft_reset
);
  typedef enum {NV_IDLE, NV_COMMIT, NV_RECALL} onac_nv_e;
  if (READY_CYCLES < 1 || NV_CYCLES < 1)
  begin : g_bad_param
    $error("onac_dev: cycle counts must be at least one");
  end
  logic soft_q;
  logic lvl1_q;
  logic lvl2_q;
  logic key_half_q;
  logic [2:0] valid_sync_q;
  logic valid_q;
  logic [31:0] ready_cnt_q;
  logic timeout_q;
  logic [1:0] ovr_sel_q;
  logic [3:0] sens_stage_q;
  logic [3:0] ch0_stage_q;
  logic [3:0] ch1_stage_q;
  logic [11:0] sens_ovr_q;
  logic [11:0] ch0_ovr_q;
  logic [11:0] ch1_ovr_q;
  onac_nv_e nv_state_q;
  logic [31:0] nv_cnt_q;
  logic nv_fixed_q;
  logic nv_unfix_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_value;
  wire logic wr_priv = link.wr && lvl2_q;
  wire logic wr_key = link.wr && link.addr == onac_pkg::ADDR_UNLOCK;
  wire logic wr_nv = wr_priv && link.addr == onac_pkg::ADDR_NV_CMD;
  wire logic nv_busy = (nv_state_q != NV_IDLE);
  // soft reset: internal soft_q one cycle after the key write, o_soft_reset pulse one cycle later
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
    begin
      soft_q <= 1'b0;
      o_soft_reset <= 1'b0;
    end
    else
    begin
      soft_q <= wr_priv && link.addr == onac_pkg::ADDR_SOFT_RESET
                && link.wdata == onac_pkg::KEY_SOFT_RESET;
      o_soft_reset <= soft_q;
    end
  // access level unlock sequence
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
    begin
      lvl1_q <= 1'b0;
      lvl2_q <= 1'b0;
      key_half_q <= 1'b0;
    end
    else if (soft_q)
    begin
      lvl1_q <= 1'b0;
      lvl2_q <= 1'b0;
      key_half_q <= 1'b0;
    end
    else if (wr_key)
    begin
      key_half_q <= (link.wdata == onac_pkg::KEY_FIRST);
      if (key_half_q && (link.wdata == onac_pkg::KEY_LEVEL_ONE
          || link.wdata == onac_pkg::KEY_LEVEL_TWO))
      begin
        lvl1_q <= 1'b1;
        lvl2_q <= (link.wdata == onac_pkg::KEY_LEVEL_TWO);
      end
    end
  // sensor valid from the analog side: three stages
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
      valid_sync_q <= 3'h0;
    else
      valid_sync_q <= {valid_sync_q[1:0], i_sensor_valid};
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
      valid_q <= 1'b0;
    else if (soft_q)
      valid_q <= 1'b0;
    else if (valid_sync_q[2] == valid_sync_q[1])
      valid_q <= valid_sync_q[2];
  // ready deadline after power-up or soft reset
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
    begin
      ready_cnt_q <= 32'h0;
      timeout_q <= 1'b0;
    end
    else if (soft_q)
    begin
      ready_cnt_q <= 32'h0;
      timeout_q <= 1'b0;
    end
    else if (!timeout_q)
    begin
      ready_cnt_q <= ready_cnt_q + 32'h1;
      timeout_q <= (ready_cnt_q == READY_CYCLES - 1);
    end
  // override select and data, committed on lower byte write
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
    begin
      ovr_sel_q <= 2'h0;
      sens_stage_q <= 4'h0;
      ch0_stage_q <= 4'h0;
      ch1_stage_q <= 4'h0;
      sens_ovr_q <= 12'h000;
      ch0_ovr_q <= 12'h000;
      ch1_ovr_q <= 12'h000;
    end
    else if (soft_q)
    begin
      ovr_sel_q <= 2'h0;
      sens_stage_q <= 4'h0;
      ch0_stage_q <= 4'h0;
      ch1_stage_q <= 4'h0;
      sens_ovr_q <= 12'h000;
      ch0_ovr_q <= 12'h000;
      ch1_ovr_q <= 12'h000;
    end
    else if (wr_priv)
    begin
      case (link.addr)
        onac_pkg::ADDR_OVR_SELECT: ovr_sel_q <= link.wdata[1:0];
        onac_pkg::ADDR_SENS_UPPER: sens_stage_q <= link.wdata[3:0];
        onac_pkg::ADDR_SENS_LOWER: sens_ovr_q <= {sens_stage_q, link.wdata};
        onac_pkg::ADDR_CH0_UPPER: ch0_stage_q <= link.wdata[3:0];
        onac_pkg::ADDR_CH0_LOWER: ch0_ovr_q <= {ch0_stage_q, link.wdata};
        onac_pkg::ADDR_CH1_UPPER: ch1_stage_q <= link.wdata[3:0];
        onac_pkg::ADDR_CH1_LOWER: ch1_ovr_q <= {ch1_stage_q, link.wdata};
        default: ;
      endcase
    end
  // registered outputs: signal path multiplexers and nv activity
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
    begin
      o_lut_index <= 12'h000;
      o_ch0_data <= 12'h000;
      o_ch1_data <= 12'h000;
      o_nv_commit <= 1'b0;
      o_nv_recall <= 1'b0;
    end
    else
    begin
      o_lut_index <= ovr_sel_q[onac_pkg::OVR_SENSOR_BIT] ? sens_ovr_q : i_sensor_temp;
      o_ch0_data <= ovr_sel_q[onac_pkg::OVR_OUTPUT_BIT] ? ch0_ovr_q : i_calc_ch0;
      o_ch1_data <= ovr_sel_q[onac_pkg::OVR_OUTPUT_BIT] ? ch1_ovr_q : i_calc_ch1;
      o_nv_commit <= (nv_state_q == NV_COMMIT);
      o_nv_recall <= (nv_state_q == NV_RECALL);
    end
  // nv commit / recall sequencer
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
    begin
      nv_state_q <= NV_IDLE;
      nv_cnt_q <= 32'h0;
    end
    else if (soft_q)
    begin
      nv_state_q <= NV_IDLE;
      nv_cnt_q <= 32'h0;
    end
    else
    begin
      case (nv_state_q)
        NV_IDLE:
        begin
          nv_cnt_q <= 32'h0;
          if (wr_nv && link.wdata == onac_pkg::CMD_NV_COMMIT)
            nv_state_q <= NV_COMMIT;
          else if (wr_nv && link.wdata == onac_pkg::CMD_NV_RECALL)
            nv_state_q <= NV_RECALL;
        end
        NV_COMMIT, NV_RECALL:
        begin
          nv_cnt_q <= nv_cnt_q + 32'h1;
          if (nv_cnt_q == NV_CYCLES - 1)
            nv_state_q <= NV_IDLE;
        end
        default: nv_state_q <= NV_IDLE;
      endcase
    end
  // error flags taken at the end of a recall only
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
    begin
      nv_fixed_q <= 1'b0;
      nv_unfix_q <= 1'b0;
    end
    else if (soft_q)
    begin
      nv_fixed_q <= 1'b0;
      nv_unfix_q <= 1'b0;
    end
    else if (nv_state_q == NV_RECALL && nv_cnt_q == NV_CYCLES - 1)
    begin
      nv_fixed_q <= i_nv_single_err && !i_nv_multi_err;
      nv_unfix_q <= i_nv_multi_err;
    end
  // read decode
  always_comb
  begin
    rd_value = onac_pkg::READ_ZERO;
    case (link.addr)
      onac_pkg::ADDR_READY_STATUS:
        rd_value = (valid_q || timeout_q) ? onac_pkg::READ_ZERO : onac_pkg::NOT_READY_VALUE;
      onac_pkg::ADDR_OVR_SELECT: rd_value = {6'h00, ovr_sel_q};
      onac_pkg::ADDR_SENS_UPPER: rd_value = {4'h0, sens_ovr_q[11:8]};
      onac_pkg::ADDR_SENS_LOWER: rd_value = sens_ovr_q[7:0];
      onac_pkg::ADDR_CH0_UPPER: rd_value = {4'h0, ch0_ovr_q[11:8]};
      onac_pkg::ADDR_CH0_LOWER: rd_value = ch0_ovr_q[7:0];
      onac_pkg::ADDR_CH1_UPPER: rd_value = {4'h0, ch1_ovr_q[11:8]};
      onac_pkg::ADDR_CH1_LOWER: rd_value = ch1_ovr_q[7:0];
      onac_pkg::ADDR_NV_CMD: rd_value = {5'h00, nv_unfix_q, nv_fixed_q, nv_busy};
      onac_pkg::ADDR_UNLOCK: rd_value = {6'h00, lvl2_q, lvl1_q};
      default: rd_value = onac_pkg::READ_ZERO;
    endcase
  end
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
      rdata_q <= 8'h00;
    else
      rdata_q <= link.rd ? rd_value : onac_pkg::READ_ZERO;
  assign link.rdata = rdata_q;
endmodule : onac_dev

// File: design/onac_host.sv
// host end: software command port driving the register link
// assumes the device end on the same clock answering reads one cycle after rd
`timescale 1ns/1ns
module onac_host (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  onac_link_if.host link,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata
);
  logic [7:0] target_q;
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  logic wr_q;
  logic rd_q;
  logic pending_q;
  logic [7:0] result_q;
  logic valid_q;
  logic refused_q;
  logic [7:0] wr_byte;
  logic wr_bad;

  // reserved select bits forced to zero, both overrides refused
  always_comb
  begin
    wr_byte = i_wdata;
    wr_bad = 1'b0;
    if (target_q == onac_pkg::ADDR_OVR_SELECT)
    begin
      wr_byte = i_wdata & onac_pkg::OVR_FIELD_MASK;
      wr_bad = (wr_byte == onac_pkg::OVR_BOTH);
    end
  end

  wire logic do_write = i_wr && i_addr == onac_pkg::HOST_WRITE && !wr_bad;
  wire logic do_read = i_wr && i_addr == onac_pkg::HOST_READ_GO;

  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
      target_q <= 8'h00;
    else if (i_wr && i_addr == onac_pkg::HOST_TARGET)
      target_q <= i_wdata;

  // key, command and reset bytes pass through unchanged
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
    begin
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      wr_q <= do_write;
      rd_q <= do_read;
      if (do_write || do_read)
        addr_q <= target_q;
      if (do_write)
        wdata_q <= wr_byte;
    end

  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
    begin
      pending_q <= 1'b0;
      result_q <= 8'h00;
      valid_q <= 1'b0;
    end
    else
    begin
      pending_q <= rd_q;
      if (pending_q)
        result_q <= link.rdata;
      if (pending_q)
        valid_q <= 1'b1;
      else if (do_read)
        valid_q <= 1'b0;
    end

  // refused flag: set wins over clear on status read
  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
      refused_q <= 1'b0;
    else if (i_wr && i_addr == onac_pkg::HOST_WRITE && wr_bad)
      refused_q <= 1'b1;
    else if (i_rd && i_addr == onac_pkg::HOST_STATUS)
      refused_q <= 1'b0;

  always_ff @(posedge i_clk_sys or posedge i_rst)
    if (i_rst)
      o_rdata <= 8'h00;
    else if (!i_rd)
      o_rdata <= 8'h00;
    else
    begin
      case (i_addr)
        onac_pkg::HOST_TARGET: o_rdata <= target_q;
        onac_pkg::HOST_RESULT: o_rdata <= result_q;
        onac_pkg::HOST_STATUS: o_rdata <= {5'h00, refused_q, valid_q, rd_q | pending_q};
        default: o_rdata <= 8'h00;
      endcase
    end

  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
  assign link.wr = wr_q;
  assign link.rd = rd_q;
endmodule : onac_host

// File: design/onac_link_if.sv
// register link between the host end and the device end
// both ends run on the same system clock
`timescale 1ns/1ns
interface onac_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : onac_link_if

// File: design/onac_pkg.sv
// constants shared by both ends of the override / nv / access register link
// assumes a 20 MHz system clock on both ends
package onac_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned READY_TIME_MS = 100;
  localparam int unsigned READY_CYCLES = READY_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned NV_BUSY_CYCLES = 4000;

  localparam logic [7:0] ADDR_READY_STATUS = 8'h07;
  localparam logic [7:0] ADDR_OVR_SELECT = 8'h08;
  localparam logic [7:0] ADDR_SENS_UPPER = 8'h09;
  localparam logic [7:0] ADDR_SENS_LOWER = 8'h0A;
  localparam logic [7:0] ADDR_CH0_UPPER = 8'h0B;
  localparam logic [7:0] ADDR_CH0_LOWER = 8'h0C;
  localparam logic [7:0] ADDR_CH1_UPPER = 8'h0D;
  localparam logic [7:0] ADDR_CH1_LOWER = 8'h0E;
  localparam logic [7:0] ADDR_NV_CMD = 8'h0F;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h10;
  localparam logic [7:0] ADDR_UNLOCK = 8'h11;

  localparam int unsigned OVR_SENSOR_BIT = 0;
  localparam int unsigned OVR_OUTPUT_BIT = 1;
  localparam logic [7:0] OVR_FIELD_MASK = 8'h03;
  localparam logic [7:0] OVR_BOTH = 8'h03;
  localparam int unsigned NV_BUSY_BIT = 0;
  localparam int unsigned NV_FIXED_BIT = 1;
  localparam int unsigned NV_UNFIXABLE_BIT = 2;
  localparam int unsigned LVL_ONE_BIT = 0;
  localparam int unsigned LVL_TWO_BIT = 1;

  localparam logic [7:0] CMD_NV_COMMIT = 8'hE4;
  localparam logic [7:0] CMD_NV_RECALL = 8'h4E;
  localparam logic [7:0] KEY_SOFT_RESET = 8'hC3;
  localparam logic [7:0] KEY_FIRST = 8'hCD;
  localparam logic [7:0] KEY_LEVEL_ONE = 8'hEF;
  localparam logic [7:0] KEY_LEVEL_TWO = 8'hF0;
  localparam logic [7:0] NOT_READY_VALUE = 8'hFF;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // host command port offsets
  localparam logic [2:0] HOST_TARGET = 3'h0;
  localparam logic [2:0] HOST_WRITE = 3'h1;
  localparam logic [2:0] HOST_READ_GO = 3'h2;
  localparam logic [2:0] HOST_RESULT = 3'h3;
  localparam logic [2:0] HOST_STATUS = 3'h4;
  localparam int unsigned HST_BUSY_BIT = 0;
  localparam int unsigned HST_VALID_BIT = 1;
  localparam int unsigned HST_REFUSED_BIT = 2;
endpackage : onac_pkg

// File: verification/onac_bench.sv
// self-checking bench: host end and device end joined by the link interface
// assumes shortened ready and nv counts set through the device parameters
`timescale 1ns/1ns
module onac_bench;
  localparam int unsigned RDY = 50;
  localparam int unsigned NVC = 16;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] h_addr = 3'h0;
  logic [7:0] h_wdata = 8'h00;
  logic h_wr = 1'b0;
  logic h_rd = 1'b0;
  logic [7:0] h_rdata;
  logic sens_valid = 1'b0;
  logic [11:0] sens_temp = 12'h123;
  logic [11:0] calc0 = 12'h456;
  logic [11:0] calc1 = 12'h789;
  logic err_single = 1'b0;
  logic err_multi = 1'b0;
  logic [11:0] lut_index, ch0_data, ch1_data;
  logic nv_commit, nv_recall, soft_reset;
  int mismatches = 0;
  int num_checks = 0;
  onac_link_if link ();
  always #25 i_clk_sys = ~i_clk_sys;
  onac_dev #(.READY_CYCLES(RDY), .NV_CYCLES(NVC)) i_onac_dev (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .link(link), .i_sensor_valid(sens_valid), .i_sensor_temp(sens_temp), .i_calc_ch0(calc0),
    .i_calc_ch1(calc1), .i_nv_single_err(err_single), .i_nv_multi_err(err_multi),
    .o_lut_index(lut_index), .o_ch0_data(ch0_data), .o_ch1_data(ch1_data), .o_nv_commit(nv_commit),
    .o_nv_recall(nv_recall), .o_soft_reset(soft_reset));
  onac_host i_onac_host (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .link(link), .i_addr(h_addr),
    .i_wdata(h_wdata), .i_wr(h_wr), .i_rd(h_rd), .o_rdata(h_rdata));
  onac_checker #(.NV_CYCLES(NVC)) i_onac_checker (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
    .o_nv_commit(nv_commit), .o_nv_recall(nv_recall), .o_soft_reset(soft_reset));
  task automatic stop_test();
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic hwr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    h_addr <= a;
    h_wdata <= d;
    h_wr <= 1'b1;
    @(posedge i_clk_sys);
    h_wr <= 1'b0;
  endtask : hwr
  task automatic hrd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    h_addr <= a;
    h_rd <= 1'b1;
    @(posedge i_clk_sys);
    h_rd <= 1'b0;
    #1;
    d = h_rdata;
  endtask : hrd
  // device write through the host port
  task automatic dwr(input logic [7:0] a, input logic [7:0] d);
    hwr(3'h0, a);
    hwr(3'h1, d);
    repeat (2) @(posedge i_clk_sys);
  endtask : dwr
  // device read through the host port, compared against exp
  task automatic drd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    hwr(3'h0, a);
    hwr(3'h2, 8'h00);
    repeat (3) @(posedge i_clk_sys);
    hrd(3'h3, v);
    check({4'h0, v}, {4'h0, exp});
  endtask : drd
  task automatic t_power_up();
    drd(8'h07, 8'hFF);
    drd(8'h08, 8'h00);
    drd(8'h0C, 8'h00);
    drd(8'h11, 8'h00);
    check(lut_index, sens_temp);
    repeat (RDY) @(posedge i_clk_sys);
    drd(8'h07, 8'h00);
  endtask : t_power_up
  task automatic t_privilege();
    dwr(8'h08, 8'h01);
    drd(8'h08, 8'h00);
    dwr(8'h11, 8'hCD);
    dwr(8'h11, 8'hEF);
    drd(8'h11, 8'h01);
    dwr(8'h0F, 8'h4E);
    drd(8'h0F, 8'h00);
    dwr(8'h10, 8'hC3);
    drd(8'h11, 8'h01);
    dwr(8'h08, 8'h01);
    drd(8'h08, 8'h00);
    dwr(8'h11, 8'hCD);
    dwr(8'h07, 8'h00);
    dwr(8'h11, 8'hF0);
    drd(8'h11, 8'h03);
  endtask : t_privilege
  task automatic t_override();
    logic [7:0] v;
    dwr(8'h09, 8'hA5);
    drd(8'h09, 8'h00);
    dwr(8'h0A, 8'h3C);
    drd(8'h09, 8'h05);
    drd(8'h0A, 8'h3C);
    dwr(8'h08, 8'h01);
    drd(8'h08, 8'h01);
    check(lut_index, 12'h53C);
    check(ch0_data, calc0);
    dwr(8'h0B, 8'h08);
    dwr(8'h0C, 8'h00);
    dwr(8'h0D, 8'h04);
    dwr(8'h0E, 8'h00);
    dwr(8'h08, 8'h02);
    drd(8'h08, 8'h02);
    check(ch0_data, 12'h800);
    check(ch1_data, 12'h400);
    check(lut_index, sens_temp);
    dwr(8'h08, 8'h03);
    hrd(3'h4, v);
    check({11'h000, v[2]}, 12'h001);
    drd(8'h08, 8'h02);
    hrd(3'h4, v);
    check({9'h000, v[2:0]}, 12'h002);
    dwr(8'h08, 8'hFC);
    drd(8'h08, 8'h00);
  endtask : t_override
  task automatic t_nv();
    @(posedge i_clk_sys);
    err_single <= 1'b1;
    dwr(8'h0F, 8'h4E);
    drd(8'h0F, 8'h01);
    check({11'h000, nv_recall}, 12'h001);
    repeat (NVC) @(posedge i_clk_sys);
    drd(8'h0F, 8'h02);
    @(posedge i_clk_sys);
    err_single <= 1'b0;
    err_multi <= 1'b1;
    dwr(8'h0F, 8'hE4);
    drd(8'h0F, 8'h03);
    check({11'h000, nv_commit}, 12'h001);
    repeat (NVC) @(posedge i_clk_sys);
    drd(8'h0F, 8'h02);
    dwr(8'h0F, 8'h4E);
    repeat (NVC) @(posedge i_clk_sys);
    drd(8'h0F, 8'h04);
  endtask : t_nv
  task automatic t_soft_reset();
    dwr(8'h10, 8'hC3);
    drd(8'h07, 8'hFF);
    @(posedge i_clk_sys);
    sens_valid <= 1'b1;
    drd(8'h07, 8'h00);
    drd(8'h11, 8'h00);
    drd(8'h08, 8'h00);
    drd(8'h0F, 8'h00);
    check(lut_index, sens_temp);
  endtask : t_soft_reset
  initial
  begin
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_power_up();
    t_privilege();
    t_override();
    t_nv();
    t_soft_reset();
    stop_test();
  end
  // cuts a hang short
  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    mismatches++;
    stop_test();
  end
endmodule : onac_bench

// File: verification/onac_checker.sv
// assertions on the register link and the device's nv and soft reset outputs
// assumes one clock, async active-high reset, read data the cycle after rd
`timescale 1ns/1ns
module onac_checker #(
  parameter int unsigned NV_CYCLES = onac_pkg::NV_BUSY_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic o_nv_commit,
  input wire logic o_nv_recall,
  input wire logic o_soft_reset
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  logic busy;
  logic soft_wr;
  logic [15:0] busy_cnt_q;
  assign busy = o_nv_commit | o_nv_recall;
  assign soft_wr = wr && addr == 8'h10 && wdata == 8'hC3;
  // length of the current nv operation
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      busy_cnt_q <= 16'h0000;
    else if (busy)
      busy_cnt_q <= busy_cnt_q + 16'h0001;
    else
      busy_cnt_q <= 16'h0000;
  end
  AST_UNLOCK_RSVD: assert property (rd && addr == 8'h11 |=> rdata[7:2] == 6'h00)
    else $error("unlock status reserved bits set");
  AST_NV_RSVD: assert property (rd && addr == 8'h0F |=> rdata[7:3] == 5'h00)
    else $error("nv status reserved bits set");
  AST_UPPER_RSVD: assert property (rd && addr inside {8'h09, 8'h0B, 8'h0D} |=> rdata[7:4] == 4'h0)
    else $error("upper override bits 7:4 not zero");
  AST_LEVEL_NEST: assert property (rd && addr == 8'h11 |=> !rdata[1] || rdata[0])
    else $error("level two shown without level one");
  AST_NV_BUSY_READ: assert property (rd && addr == 8'h0F |=> rdata[0] == busy)
    else $error("nv busy bit disagrees with running operation");
  AST_NV_LENGTH: assert property ($fell(busy) |-> busy_cnt_q == NV_CYCLES)
    else $error("nv operation length wrong");
  AST_COMMIT_CAUSE: assert property ($rose(o_nv_commit) |->
    $past(wr, 2) && $past(addr, 2) == 8'h0F && $past(wdata, 2) == 8'hE4)
    else $error("commit started without its command");
  AST_RECALL_CAUSE: assert property ($rose(o_nv_recall) |->
    $past(wr, 2) && $past(addr, 2) == 8'h0F && $past(wdata, 2) == 8'h4E)
    else $error("recall started without its command");
  AST_NV_EXCL: assert property (!(o_nv_commit && o_nv_recall))
    else $error("commit and recall at once");
  AST_SOFT_CAUSE: assert property ($rose(o_soft_reset) |-> $past(soft_wr, 2) || $past(soft_wr, 3))
    else $error("soft reset without its key");
  AST_SOFT_PULSE: assert property (o_soft_reset |=> !o_soft_reset)
    else $error("soft reset pulse too long");
  cover property ($rose(o_nv_commit));
  cover property ($rose(o_nv_recall));
  cover property (o_soft_reset);
  cover property (rd && addr == 8'h11 ##1 rdata == 8'h03);
endmodule : onac_checker
